// >>> design/ubg_pkg.sv
// Shared constants of the baud generator and direction enable block
`default_nettype none
package ubg_pkg;
    // Clock source select codes
    localparam logic [1:0] SRC_PERIPH     = 2'h0;
    localparam logic [1:0] SRC_PERIPH_DIV = 2'h1;
    localparam logic [1:0] SRC_EXT_ALT    = 2'h2;
    localparam logic [1:0] SRC_EXTERNAL   = 2'h3;

    // Fixed prescaler applied to the peripheral clock for the divided source
    localparam int unsigned PRESCALE_DIV = 8;

    // Field widths
    localparam int unsigned DIVISOR_W  = 16;
    localparam int unsigned FRACTION_W = 3;
    localparam int unsigned MODE_W     = 4;

    // Operating mode codes
    localparam logic [3:0] MODE_NORMAL    = 4'h0;
    localparam logic [3:0] MODE_SPI_MASTER = 4'he;
    localparam logic [3:0] MODE_SPI_SLAVE = 4'hf;

    // Oversampling ratios, selected by the oversample select bit
    localparam int unsigned OVS_BY16 = 16;
    localparam int unsigned OVS_BY8  = 8;
    localparam int unsigned OVS_W    = 4;

    // Divisor values with special meaning
    localparam logic [15:0] DIVISOR_STOP   = 16'h0000;
    localparam logic [15:0] DIVISOR_BYPASS = 16'h0001;

    // Reset values of the enable state
    localparam logic RX_ENABLE_RST = 1'b0;
    localparam logic TX_ENABLE_RST = 1'b0;
endpackage : ubg_pkg
`default_nettype wire

// >>> design/ubg_core.sv
// Baud rate generator and receiver/transmitter enable control of a serial port
//
// Notes on behaviour
// - Source: peripheral clock, clock/8, or serial pin
// - 16-bit divisor; zero divisor stops all ticks except in sync mode with SRC_EXTERNAL source
// - Divisor one bypasses divider, source passes through
// - Async: divided clock samples; baud divides 16/8
// - Fraction adds eighth steps to the divisor
// - Fraction applies only in normal asynchronous mode
// - Sync internal: bit clock is source over divisor
// - Sync SRC_EXTERNAL source: pin is bit clock directly; SRC_EXT_ALT pin is divided
// - Periph source odd divisor still near 50:50
// - Receiver disabled after reset until enabled
// - Transmitter disabled after reset until enabled
// - Directions enable together or independently
// - Soft reset pulses engines, keeps enables and configuration
// - Receiver disable waits for current character end
// - Transmitter disable waits for shift, holding, timeguard
// - Disabled transmitter shows both ready flags low
`default_nettype none
module ubg_core #(
    parameter int unsigned DIV_W    = ubg_pkg::DIVISOR_W,
    parameter int unsigned FRAC_W   = ubg_pkg::FRACTION_W,
    parameter int unsigned PRESCALE = ubg_pkg::PRESCALE_DIV
) (
    input  wire logic              clk_i,
    input  wire logic              nrst_i,
    // Configuration, held steady by software
    input  wire logic [1:0]        clock_source_select_i,
    input  wire logic [DIV_W-1:0]  baud_divisor_i,
    input  wire logic [FRAC_W-1:0] fraction_field_i,
    input  wire logic              oversample_sel_i,
    input  wire logic              sync_mode_i,
    input  wire logic [3:0]        operating_mode_i,
    input  wire logic              clock_output_enable_i,
    // Serial clock pin, input side (asynchronous)
    input  wire logic              serial_clock_i,
    // Command strobes
    input  wire logic              receiver_enable_cmd_i,
    input  wire logic              receiver_disable_cmd_i,
    input  wire logic              receiver_reset_cmd_i,
    input  wire logic              transmitter_enable_cmd_i,
    input  wire logic              transmitter_disable_cmd_i,
    input  wire logic              transmitter_reset_cmd_i,
    // State reported by the receive and transmit engines
    input  wire logic              rx_char_busy_i,
    input  wire logic              tx_shift_busy_i,
    input  wire logic              tx_holding_full_i,
    input  wire logic              tx_timeguard_busy_i,
    // Generated timing enables
    output logic                   sample_tick_o,
    output logic                   baud_tick_o,
    // Serial clock pin, output side
    output logic                   serial_clock_o,
    output logic                   serial_clock_oe_o,
    // Direction control and status
    output logic                   rx_enabled_o,
    output logic                   tx_enabled_o,
    output logic                   rx_soft_reset_o,
    output logic                   tx_soft_reset_o,
    output logic                   tx_holding_free_flag_o,
    output logic                   tx_idle_flag_o
);

    localparam int unsigned PRE_W = $clog2(PRESCALE);

    // Elaboration-time checks on the parameters
    if (DIV_W != ubg_pkg::DIVISOR_W)
    begin : g_bad_div
        $error("divisor width must match the 16-bit divisor field");
    end
    if (FRAC_W != ubg_pkg::FRACTION_W)
    begin : g_bad_frac
        $error("fraction width must give eighth steps");
    end
    if (PRESCALE < 2 || (PRESCALE & (PRESCALE - 1)) != 0)
    begin : g_bad_pre
        $error("prescaler must be a power of two of at least 2");
    end

    // Mode decode
    logic is_spi;
    logic async_normal;
    logic ext_source;
    assign is_spi       = (operating_mode_i == ubg_pkg::MODE_SPI_MASTER)
                       || (operating_mode_i == ubg_pkg::MODE_SPI_SLAVE);
    assign async_normal = !sync_mode_i && !is_spi
                       && (operating_mode_i == ubg_pkg::MODE_NORMAL);
    assign ext_source   = clock_source_select_i[1];

    // Serial clock pin synchroniser; first stage feeds only the second
    logic sck_meta;
    logic sck_sync;
    logic sck_prev;
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            sck_meta <= 1'b0;
            sck_sync <= 1'b0;
            sck_prev <= 1'b0;
        end
        else
        begin
            sck_meta <= serial_clock_i;
            sck_sync <= sck_meta;
            sck_prev <= sck_sync;
        end
    end

    // Rising edge of the external clock; the partner keeps it slow enough
    logic ext_rise;
    assign ext_rise = sck_sync && !sck_prev;
    // Fixed prescaler for the divided peripheral clock source
    logic [PRE_W-1:0] pre_cnt;
    logic             pre_tick;
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            pre_cnt <= '0;
        else
            pre_cnt <= pre_cnt + 1'b1;
    end
    assign pre_tick = (pre_cnt == PRE_W'(PRESCALE - 1));

    // Source enable: one pulse per period of the selected source
    logic src_tick;
    always_comb
    begin
        case (clock_source_select_i)
            ubg_pkg::SRC_PERIPH:     src_tick = 1'b1;
            ubg_pkg::SRC_PERIPH_DIV: src_tick = pre_tick;
            default:                 src_tick = ext_rise;
        endcase
    end

    // Fractional accumulator decides whether this period is one longer
    logic [FRAC_W-1:0] frac_acc;
    logic [FRAC_W:0]   frac_sum;
    logic              frac_extra;
    assign frac_sum   = {1'b0, frac_acc} + {1'b0, fraction_field_i};
    assign frac_extra = async_normal && (fraction_field_i != '0)
                     && frac_sum[FRAC_W];

    // Divider period in source ticks, stretched by one on a fraction carry
    logic [DIV_W:0] period;
    logic [DIV_W:0] half;
    assign period = {1'b0, baud_divisor_i} + {{DIV_W{1'b0}}, frac_extra};
    assign half   = {2'b00, baud_divisor_i[DIV_W-1:1]};

    logic div_stop;
    logic div_bypass;
    assign div_stop   = (baud_divisor_i == ubg_pkg::DIVISOR_STOP);
    assign div_bypass = (baud_divisor_i == ubg_pkg::DIVISOR_BYPASS)
                     && !frac_extra;

    // Divider counter over source ticks
    logic [DIV_W:0] div_cnt;
    logic           div_end;
    logic           div_tick;
    assign div_end  = (div_cnt >= period - 1'b1);
    assign div_tick = src_tick && !div_stop && (div_bypass || div_end);
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            div_cnt  <= '0;
            frac_acc <= '0;
        end
        else if (div_stop || div_bypass)
            div_cnt <= '0;
        else if (src_tick)
        begin
            if (div_end)
            begin
                div_cnt  <= '0;
                frac_acc <= async_normal ? frac_sum[FRAC_W-1:0] : '0;
            end
            else
                div_cnt <= div_cnt + 1'b1;
        end
    end
    // Oversampling divider: baud tick every 16 or 8 sample ticks; unused in sync and SPI modes
    localparam int unsigned OVS_W_L = ubg_pkg::OVS_W;
    logic [OVS_W_L-1:0] ovs_cnt;
    logic [OVS_W_L-1:0] ovs_last;
    assign ovs_last = oversample_sel_i ? OVS_W_L'(ubg_pkg::OVS_BY8 - 1)
                                       : OVS_W_L'(ubg_pkg::OVS_BY16 - 1);
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            ovs_cnt <= '0;
        else if (sync_mode_i || is_spi || div_stop)
            ovs_cnt <= '0;
        else if (div_tick)
            ovs_cnt <= (ovs_cnt >= ovs_last) ? '0 : ovs_cnt + 1'b1;
    end
    // Tick outputs registered so they line up with the data flops downstream
    logic sync_ext;
    assign sync_ext = sync_mode_i && (clock_source_select_i == ubg_pkg::SRC_EXTERNAL);
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            sample_tick_o <= 1'b0;
            baud_tick_o   <= 1'b0;
        end
        else if (sync_ext)
        begin
            sample_tick_o <= ext_rise;
            baud_tick_o   <= ext_rise;
        end
        else if (sync_mode_i || is_spi)
        begin
            sample_tick_o <= div_tick;
            baud_tick_o   <= div_tick;
        end
        else
        begin
            sample_tick_o <= div_tick;
            baud_tick_o   <= div_tick && (ovs_cnt >= ovs_last);
        end
    end
    // Serial clock output toggles at mid and end of each divider period.
    // With a peripheral source the half point is counted in clock cycles,
    // so odd divisors stay within one cycle of 50:50; slower sources need
    // an even divisor from software.
    logic half_hit;
    assign half_hit = src_tick && !div_stop && !div_bypass
                   && (half != '0) && (div_cnt == half - 1'b1);
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            serial_clock_o <= 1'b0;
        else if (!sync_mode_i)
            serial_clock_o <= 1'b0;
        else if (div_tick || half_hit)
            serial_clock_o <= !serial_clock_o;
    end
    // Drive the pin only as clock master from an internal source
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            serial_clock_oe_o <= 1'b0;
        else
            serial_clock_oe_o <= sync_mode_i && clock_output_enable_i && !ext_source;
    end
    // Receiver enable with deferred disable
    logic rx_dis_pending;
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rx_enabled_o   <= ubg_pkg::RX_ENABLE_RST;
            rx_dis_pending <= 1'b0;
        end
        else if (receiver_reset_cmd_i)
            rx_dis_pending <= 1'b0;
        else if (receiver_disable_cmd_i || rx_dis_pending)
        begin
            // Current character must finish before reception stops
            if (rx_char_busy_i && rx_enabled_o)
                rx_dis_pending <= 1'b1;
            else
            begin
                rx_enabled_o   <= 1'b0;
                rx_dis_pending <= 1'b0;
            end
        end
        else if (receiver_enable_cmd_i)
            rx_enabled_o <= 1'b1;
    end
    // Transmitter enable with deferred disable
    logic tx_dis_pending;
    logic tx_drained;
    assign tx_drained = !tx_shift_busy_i && !tx_holding_full_i && !tx_timeguard_busy_i;
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            tx_enabled_o   <= ubg_pkg::TX_ENABLE_RST;
            tx_dis_pending <= 1'b0;
        end
        else if (transmitter_reset_cmd_i)
            tx_dis_pending <= 1'b0;
        else if (transmitter_disable_cmd_i || tx_dis_pending)
        begin
            // Both shift and holding characters, then the timeguard, first
            if (!tx_drained && tx_enabled_o)
                tx_dis_pending <= 1'b1;
            else
            begin
                tx_enabled_o   <= 1'b0;
                tx_dis_pending <= 1'b0;
            end
        end
        else if (transmitter_enable_cmd_i)
            tx_enabled_o <= 1'b1;
    end
    // Soft reset pulses to the engines; configuration inputs are untouched
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rx_soft_reset_o <= 1'b0;
            tx_soft_reset_o <= 1'b0;
        end
        else
        begin
            rx_soft_reset_o <= receiver_reset_cmd_i;
            tx_soft_reset_o <= transmitter_reset_cmd_i;
        end
    end
    // Transmit status flags, forced low while disabled or in soft reset
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            tx_holding_free_flag_o <= 1'b0;
            tx_idle_flag_o         <= 1'b0;
        end
        else if (!tx_enabled_o || transmitter_reset_cmd_i)
        begin
            tx_holding_free_flag_o <= 1'b0;
            tx_idle_flag_o         <= 1'b0;
        end
        else
        begin
            tx_holding_free_flag_o <= !tx_holding_full_i;
            tx_idle_flag_o         <= !tx_holding_full_i && !tx_shift_busy_i;
        end
    end
endmodule : ubg_core
`default_nettype wire

// >>> bench/ubg_core_chk.sv
// Assertion checker on the ports of the baud generator and enable block
`default_nettype none
module ubg_core_chk #(
    parameter int unsigned DIV_W    = ubg_pkg::DIVISOR_W,
    parameter int unsigned FRAC_W   = ubg_pkg::FRACTION_W,
    parameter int unsigned PRESCALE = ubg_pkg::PRESCALE_DIV
) (
    input wire logic              clk_i,
    input wire logic              nrst_i,
    input wire logic [1:0]        clock_source_select_i,
    input wire logic [DIV_W-1:0]  baud_divisor_i,
    input wire logic [FRAC_W-1:0] fraction_field_i,
    input wire logic              sync_mode_i,
    input wire logic              receiver_enable_cmd_i,
    input wire logic              receiver_disable_cmd_i,
    input wire logic              receiver_reset_cmd_i,
    input wire logic              transmitter_enable_cmd_i,
    input wire logic              transmitter_disable_cmd_i,
    input wire logic              transmitter_reset_cmd_i,
    input wire logic              rx_char_busy_i,
    input wire logic              tx_shift_busy_i,
    input wire logic              tx_holding_full_i,
    input wire logic              sample_tick_o,
    input wire logic              baud_tick_o,
    input wire logic              rx_enabled_o,
    input wire logic              tx_enabled_o,
    input wire logic              rx_soft_reset_o,
    input wire logic              tx_soft_reset_o,
    input wire logic              tx_holding_free_flag_o,
    input wire logic              tx_idle_flag_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    // Direction enables: strobes act at the next edge, disable beats enable
    a_rx_enable_cmd: assert property (receiver_enable_cmd_i && !receiver_disable_cmd_i
        && !receiver_reset_cmd_i && !rx_enabled_o |=> rx_enabled_o) else $error("rx not enabled");
    a_tx_enable_cmd: assert property (transmitter_enable_cmd_i && !transmitter_disable_cmd_i
        && !transmitter_reset_cmd_i && !tx_enabled_o |=> tx_enabled_o) else $error("tx not enabled");
    a_rx_idle_disable: assert property (receiver_disable_cmd_i && !receiver_reset_cmd_i
        && !rx_char_busy_i |=> !rx_enabled_o) else $error("rx disable not taken");
    // A disable while busy must wait for the work in hand
    a_rx_busy_hold: assert property (rx_enabled_o && receiver_disable_cmd_i && rx_char_busy_i
        |=> rx_enabled_o) else $error("rx dropped mid character");
    a_tx_busy_hold: assert property (tx_enabled_o && transmitter_disable_cmd_i
        && (tx_shift_busy_i || tx_holding_full_i) |=> tx_enabled_o) else $error("tx dropped early");
    // Soft resets pulse out one cycle later; flags are cleared with them
    a_rx_soft_reset: assert property (receiver_reset_cmd_i |=> rx_soft_reset_o)
        else $error("rx soft reset missing");
    a_tx_soft_reset: assert property (transmitter_reset_cmd_i |=> tx_soft_reset_o
        && !tx_holding_free_flag_o && !tx_idle_flag_o) else $error("tx soft reset wrong");
    a_tx_flags_off: assert property (!$past(tx_enabled_o) |->
        !tx_holding_free_flag_o && !tx_idle_flag_o) else $error("flags high while disabled");
    // Tick generation: zero divisor stops, divisor one bypasses, baud rides on a sample
    a_zero_stop: assert property ((baud_divisor_i == '0 && !(sync_mode_i
        && clock_source_select_i[1]))[*4] |-> !sample_tick_o && !baud_tick_o)
        else $error("tick with zero divisor");
    a_bypass_tick: assert property ((clock_source_select_i == 2'h0 && baud_divisor_i == 1
        && fraction_field_i == '0)[*4] |-> sample_tick_o) else $error("bypass tick missing");
    a_baud_pair: assert property (baud_tick_o |-> sample_tick_o)
        else $error("baud tick without sample tick");
endmodule : ubg_core_chk
bind ubg_core ubg_core_chk #(.DIV_W(DIV_W), .FRAC_W(FRAC_W), .PRESCALE(PRESCALE)) chk_u (
    .clk_i, .nrst_i, .clock_source_select_i, .baud_divisor_i, .fraction_field_i, .sync_mode_i,
    .receiver_enable_cmd_i, .receiver_disable_cmd_i, .receiver_reset_cmd_i,
    .transmitter_enable_cmd_i, .transmitter_disable_cmd_i, .transmitter_reset_cmd_i,
    .rx_char_busy_i, .tx_shift_busy_i, .tx_holding_full_i, .sample_tick_o, .baud_tick_o,
    .rx_enabled_o, .tx_enabled_o, .rx_soft_reset_o, .tx_soft_reset_o,
    .tx_holding_free_flag_o, .tx_idle_flag_o
);
`default_nettype wire

// >>> bench/ubg_remote_model.sv
// Remote transceiver model that supplies the external serial clock
`default_nettype none
module ubg_remote_model #(
    parameter int HALF_NS = 16
) (
    input  wire logic run_i,
    output var logic  sck_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // Clock stands still low outside frames; phases span several system clocks
    initial
    begin
        sck_o = 1'b0;
        forever
        begin
            wait (run_i);
            #1;
            while (run_i)
            begin
                #(HALF_NS) sck_o = ~sck_o;
            end
            sck_o = 1'b0;
        end
    end
endmodule : ubg_remote_model
`default_nettype wire

// >>> bench/test_usart_baud_gen_and_enable_ctrl.sv
// Self-checking testbench for the baud generator and enable block
`default_nettype none
module test_usart_baud_gen_and_enable_ctrl;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_i = 1'b0, nrst_i = 1'b0, oversample_sel_i = 1'b0, sync_mode_i = 1'b0;
    logic        clock_output_enable_i = 1'b0, ext_run = 1'b0;
    logic [1:0]  clock_source_select_i = 2'h0;
    logic [15:0] baud_divisor_i = 16'h0002;
    logic [2:0]  fraction_field_i = 3'h0;
    logic [3:0]  operating_mode_i = 4'h0, eng = 4'h0;
    logic [5:0]  cmd = 6'h00;
    wire logic   sample_tick_o, baud_tick_o, serial_clock_o, serial_clock_oe_o, ext_sck;
    wire logic   rx_enabled_o, tx_enabled_o, rx_soft_reset_o, tx_soft_reset_o;
    wire logic   tx_holding_free_flag_o, tx_idle_flag_o, serial_clock_i;
    int          err_count = 0;
    int          n_compared = 0;
    int          t_src[9] = '{0, 0, 1, 0, 0, 0, 0, 3, 3};
    int          t_cd[9]  = '{2, 3, 1, 1, 5, 2, 2, 0, 2};
    int          t_fp[9]  = '{0, 0, 0, 0, 4, 4, 4, 0, 0};
    int          t_ovr[9] = '{1, 0, 1, 0, 0, 1, 1, 0, 1};
    int          t_syn[9] = '{0, 0, 0, 1, 1, 0, 0, 1, 0};
    int          t_mod[9] = '{0, 0, 0, 0, 0, 0, 14, 0, 0};

    // Pin level: the block drives it when enabled, otherwise the remote end
    assign serial_clock_i = serial_clock_oe_o ? serial_clock_o : ext_sck;
    always #2 clk_i = ~clk_i;

    ubg_core dut_u (
        .clk_i, .nrst_i, .clock_source_select_i, .baud_divisor_i, .fraction_field_i,
        .oversample_sel_i, .sync_mode_i, .operating_mode_i, .clock_output_enable_i,
        .serial_clock_i, .receiver_enable_cmd_i(cmd[5]), .receiver_disable_cmd_i(cmd[4]),
        .receiver_reset_cmd_i(cmd[3]), .transmitter_enable_cmd_i(cmd[2]),
        .transmitter_disable_cmd_i(cmd[1]), .transmitter_reset_cmd_i(cmd[0]),
        .rx_char_busy_i(eng[3]), .tx_shift_busy_i(eng[2]), .tx_holding_full_i(eng[1]),
        .tx_timeguard_busy_i(eng[0]), .sample_tick_o, .baud_tick_o, .serial_clock_o,
        .serial_clock_oe_o, .rx_enabled_o, .tx_enabled_o, .rx_soft_reset_o, .tx_soft_reset_o,
        .tx_holding_free_flag_o, .tx_idle_flag_o
    );
    ubg_remote_model remote_u (.run_i(ext_run), .sck_o(ext_sck));

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value %s: expected %0d, seen %0d", what, exp, seen);
        end
    endtask : check

    // One-cycle command strobe; returns where the outcome is visible
    task automatic strobe(input logic [5:0] c);
        @(negedge clk_i);
        cmd = c;
        @(negedge clk_i);
        cmd = 6'h00;
    endtask : strobe

    // Cycles spanned by n tick periods, after two ticks to let the divider settle
    task automatic measure(input logic sel, input int n, output int cyc);
        int seen;
        seen = -2;
        cyc = 0;
        for (int lim = 0; seen < n; lim++)
        begin
            if (lim > 5000)
            begin
                check("tick timeout", 32'h1, 32'h0);
                give_verdict();
            end
            @(negedge clk_i);
            if (seen >= 0)
                cyc++;
            if ((sel ? baud_tick_o : sample_tick_o) === 1'b1)
                seen++;
        end
    endtask : measure

    task automatic t_enables;
        @(negedge clk_i);
        check("rx_en", rx_enabled_o, 32'h0);
        check("tx flags", {tx_holding_free_flag_o, tx_idle_flag_o, tx_enabled_o}, 32'h0);
        strobe(6'h24);
        check("both en", {rx_enabled_o, tx_enabled_o}, 32'h3);
        @(negedge clk_i);
        check("tx flags", {tx_holding_free_flag_o, tx_idle_flag_o}, 32'h3);
        strobe(6'h10);
        check("rx off tx on", {rx_enabled_o, tx_enabled_o}, 32'h1);
        strobe(6'h30);
        check("dis beats en", rx_enabled_o, 32'h0);
        strobe(6'h02);
        @(negedge clk_i);
        check("tx off flags", {tx_enabled_o, tx_holding_free_flag_o, tx_idle_flag_o}, 32'h0);
    endtask : t_enables

    // Disable while busy is deferred; an enable in the meantime is ignored
    task automatic t_busy_disable;
        strobe(6'h24);
        eng = 4'he;
        strobe(6'h12);
        strobe(6'h20);
        check("rx held", rx_enabled_o, 32'h1);
        eng = 4'h7;
        @(negedge clk_i);
        @(negedge clk_i);
        check("rx stop", rx_enabled_o, 32'h0);
        check("tx held", {tx_enabled_o, tx_holding_free_flag_o}, 32'h2);
        eng = 4'h5;
        repeat (3) @(negedge clk_i);
        check("holding freed", {tx_enabled_o, tx_holding_free_flag_o}, 32'h3);
        eng = 4'h1;
        repeat (3) @(negedge clk_i);
        check("timeguard held", tx_enabled_o, 32'h1);
        eng = 4'h0;
        @(negedge clk_i);
        check("tx stop", tx_enabled_o, 32'h0);
        @(negedge clk_i);
        check("flags low", {tx_holding_free_flag_o, tx_idle_flag_o}, 32'h0);
    endtask : t_busy_disable

    // Soft reset pulses and clears flags but keeps enables; it drops a disable strobed in the same cycle
    task automatic t_soft_reset;
        strobe(6'h24);
        eng = 4'h8;
        strobe(6'h19);
        check("resets", {rx_soft_reset_o, tx_soft_reset_o, tx_holding_free_flag_o}, 32'h6);
        eng = 4'h0;
        @(negedge clk_i);
        check("after reset", {rx_soft_reset_o, rx_enabled_o, tx_enabled_o}, 32'h3);
    endtask : t_soft_reset

    task automatic t_ticks;
        int cd;
        int s8;
        int cyc;
        int bd;
        for (int i = 0; i < 9; i++)
        begin
            @(negedge clk_i);
            clock_source_select_i = 2'(t_src[i]);
            baud_divisor_i = 16'(t_cd[i]);
            fraction_field_i = 3'(t_fp[i]);
            oversample_sel_i = 1'(t_ovr[i]);
            sync_mode_i = 1'(t_syn[i]);
            operating_mode_i = 4'(t_mod[i]);
            ext_run = (t_src[i] == 3);
            cd = (t_syn[i] == 1 && t_src[i] == 3) ? 1 : t_cd[i];
            s8 = (t_src[i] == 0 ? 1 : 8) * (8 * cd + (t_syn[i] + t_mod[i] == 0 ? t_fp[i] : 0));
            measure(1'b0, 8, cyc);
            check("sample span", 32'(cyc), 32'(s8));
            measure(1'b1, 1, cyc);
            // Synchronous and SPI modes skip the oversampling division
            bd = (t_syn[i] + t_mod[i] != 0) ? s8 / 8 : s8 * (t_ovr[i] ? 1 : 2);
            check("baud span", 32'(cyc), 32'(bd));
        end
        ext_run = 1'b0;
    endtask : t_ticks

    // Zero divisor gives no ticks; even divisor master clock is 50:50 on the pin
    task automatic t_stop_and_duty;
        int cnt;
        cnt = 0;
        @(negedge clk_i);
        {clock_source_select_i, sync_mode_i, baud_divisor_i} = {2'h0, 1'b0, 16'h0000};
        repeat (64) @(negedge clk_i) cnt += sample_tick_o + baud_tick_o;
        check("ticks at zero", 32'(cnt), 32'h0);
        {sync_mode_i, clock_output_enable_i, baud_divisor_i} = {2'h3, 16'h0004};
        repeat (16) @(negedge clk_i);
        cnt = 0;
        repeat (16) @(negedge clk_i) cnt += serial_clock_o;
        check("high count", 32'(cnt), 32'h8);
        check("pin driven", serial_clock_oe_o, 32'h1);
    endtask : t_stop_and_duty

    initial
    begin
        repeat (5) @(negedge clk_i);
        nrst_i = 1'b1;
        t_enables();
        t_busy_disable();
        t_soft_reset();
        t_ticks();
        t_stop_and_duty();
        give_verdict();
    end
endmodule : test_usart_baud_gen_and_enable_ctrl
`default_nettype wire
